// ### rtl/wdtrt_pkg.sv
package wdtrt_pkg;

  // Register byte addresses on the APB slave.
  localparam logic [11:0] ADDR_CLKSEL = 12'h000;
  localparam logic [11:0] ADDR_CTRL   = 12'h004;
  localparam logic [11:0] ADDR_KEY    = 12'h008;

  // Field positions.
  localparam int DEBUG_RUN_ENABLE_BIT   = 8;
  localparam int DIV_LSB     = 4;
  localparam int SRC_LSB     = 0;
  localparam int RESTART_BIT = 4;
  localparam int RUN_LSB     = 0;

  // Keyed values.
  localparam logic [3:0]  RUN_STOP_CODE = 4'ha;
  localparam logic [3:0]  RUN_ACT_READ  = 4'h0;
  localparam logic [15:0] UNLOCK_KEY    = 16'h0096;

  // Reset values.
  localparam logic        DEBUG_RUN_ENABLE_RST = 1'h0;
  localparam logic [1:0]  DIV_RST   = 2'h0;
  localparam logic [1:0]  SRC_RST   = 2'h0;
  localparam logic [15:0] KEY_RST   = 16'h0000;

  // Source select codes.
  localparam logic [1:0] SRC_INTERNAL  = 2'h0;
  localparam logic [1:0] SRC_LOWSPEED  = 2'h1;
  localparam logic [1:0] SRC_HIGHSPEED = 2'h2;
  localparam logic [1:0] SRC_EXTERNAL  = 2'h3;
  localparam int         NUM_SRC       = 4;

  // Prescaler terminal counts: ratio minus one.
  localparam logic [15:0] TERM_8K   = 16'h1fff;
  localparam logic [15:0] TERM_16K  = 16'h3fff;
  localparam logic [15:0] TERM_32K  = 16'h7fff;
  localparam logic [15:0] TERM_64K  = 16'hffff;
  localparam logic [15:0] TERM_LOW  = 16'h007f;
  localparam logic [15:0] TERM_EXT  = 16'h0000;

  // Watchdog counter.
  localparam int         CNT_W   = 10;
  localparam logic [9:0] CNT_MAX = 10'h3ff;

  typedef enum logic {RUN_STOPPED, RUN_ACTIVE} wdtrt_run_type;

endpackage

// ### rtl/wdtrt_cnt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface wdtrt_cnt_if;
  import wdtrt_pkg::*;
  logic             tick;
  logic             clear;
  logic             run;
  logic             overflow;
  logic [CNT_W-1:0] count;

  modport ctl (output tick, output clear, output run, input count, input overflow);
  modport cnt (input tick, input clear, input run, output count, output overflow);
endinterface
`default_nettype wire

// ### rtl/wdtrt_counter.sv
`timescale 1ns/1ps
`default_nettype none
module wdtrt_counter
  import wdtrt_pkg::*;
(
  input wire logic  sys_clk,
  input wire logic  rstn,
  input wire logic  clkEn,
  wdtrt_cnt_if.cnt  cntBus
);

  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic             ovf;

  // Clear beats a tick so a restart always starts a full period.
  always_comb
  begin
    count_d = count_q;
    ovf     = 1'b0;
    if (cntBus.clear)
      count_d = '0;
    else if (cntBus.run && cntBus.tick)
    begin
      count_d = CNT_W'(count_q + 1'b1);
      ovf     = (count_q == CNT_MAX);
    end
  end

  // State register; the count wraps to zero on overflow.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      count_q <= '0;
    else if (clkEn)
      count_q <= count_d;
  end

  assign cntBus.count    = count_q;
  assign cntBus.overflow = ovf;

  // One tick advances the count by exactly one.
  a_count_step: assert property (@(posedge sys_clk) disable iff (!rstn)
    clkEn && cntBus.run && cntBus.tick && !cntBus.clear
    |=> cntBus.count == $past(cntBus.count) + 10'h001)
    else $error("Counter did not advance by one on a tick.");

endmodule
`default_nettype wire

// ### rtl/wdtrt_top.sv
`timescale 1ns/1ps
`default_nettype none
module wdtrt_top
  import wdtrt_pkg::*;
#(
  parameter logic [NUM_SRC-1:0] SRC_AVAIL = 4'hf
)
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        clkEn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        internalOsc,
  input  wire logic        lowSpeedXtal,
  input  wire logic        highSpeedOsc,
  input  wire logic        extClkIn,
  input  wire logic        debugMode,
  output logic             systemResetReq
);

  wdtrt_cnt_if cntBus ();

  logic [NUM_SRC-1:0] srcPins;
  logic [NUM_SRC-1:0] srcEdge;
  logic               selEdge;
  logic               gateOpen;
  logic               running;
  logic               advance;
  logic               unlocked;
  logic               addrHit;
  logic               wrXfer;
  logic               rdStart;
  logic               restartHit;
  logic [15:0]        term;

  logic               debug_run_enable_q;
  logic               debug_run_enable_d;
  logic [1:0]         div_q;
  logic [1:0]         div_d;
  logic [1:0]         src_q;
  logic [1:0]         src_d;
  logic [15:0]        key_q;
  logic [15:0]        key_d;
  wdtrt_run_type      run_q;
  wdtrt_run_type      run_d;
  logic [15:0]        preCnt_q;
  logic [15:0]        preCnt_d;
  logic               tick;
  logic [31:0]        prdata_q;
  logic [31:0]        prdata_d;
  logic               pready_q;
  logic               pready_d;
  logic               pslverr_q;
  logic               pslverr_d;
  logic               rstReq_q;
  logic               rstReq_d;

  // Source pins in select-code order.
  assign srcPins = {extClkIn, highSpeedOsc, lowSpeedXtal, internalOsc};

  // Each source pin is resynchronised and edge detected on sys_clk.
  // A source must stay below half of sys_clk or edges are lost.
  genvar i;
  for (i = 0; i < NUM_SRC; i++)
  begin : g_src
    logic [2:0] sh_q;
    logic [2:0] sh_d;

    always_comb
    begin
      sh_d = {sh_q[1:0], srcPins[i]};
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
      if (!rstn)
        sh_q <= 3'h0;
      else if (clkEn)
        sh_q <= sh_d;
    end

    assign srcEdge[i] = sh_q[1] & ~sh_q[2];
  end

  // Prescaler terminal count for the selected source and divider.
  always_comb
  begin
    term = TERM_EXT;
    unique case (src_q)
      SRC_INTERNAL, SRC_HIGHSPEED:
      begin
        unique case (div_q)
          2'h0: term = TERM_8K;
          2'h1: term = TERM_16K;
          2'h2: term = TERM_32K;
          2'h3: term = TERM_64K;
        endcase
      end
      SRC_LOWSPEED:  term = TERM_LOW;
      SRC_EXTERNAL:  term = TERM_EXT;
    endcase
  end

  // Counting needs only the source edge, the debug gate and the run state.
  // Halt is deliberately not an input: the count goes on through it.
  // A source that stops in sleep simply delivers no edges, holding state.
  assign selEdge  = srcEdge[src_q];
  assign gateOpen = debug_run_enable_q | ~debugMode;
  assign running  = (run_q == RUN_ACTIVE);
  assign advance  = selEdge & gateOpen & running;

  // APB decode; pready is registered, so every access has one wait state.
  assign unlocked = (key_q == UNLOCK_KEY);
  assign addrHit  = (paddr == ADDR_CLKSEL) | (paddr == ADDR_CTRL) | (paddr == ADDR_KEY);
  assign wrXfer   = psel & penable & pready_q & pwrite;
  assign rdStart  = psel & penable & ~pready_q & ~pwrite;
  assign restartHit = wrXfer & (paddr == ADDR_CTRL) & unlocked
                    & pwdata[RESTART_BIT];

  // Configuration next values; locked writes are dropped silently.
  always_comb
  begin
    debug_run_enable_d = debug_run_enable_q;
    div_d   = div_q;
    src_d   = src_q;
    key_d   = key_q;
    run_d   = run_q;
    if (wrXfer && paddr == ADDR_KEY)
      key_d = pwdata[15:0];
    if (wrXfer && unlocked && paddr == ADDR_CLKSEL)
    begin
      debug_run_enable_d = pwdata[DEBUG_RUN_ENABLE_BIT];
      div_d   = pwdata[DIV_LSB +: 2];
      if (SRC_AVAIL[pwdata[SRC_LSB +: 2]])
        src_d = pwdata[SRC_LSB +: 2];
    end
    if (wrXfer && unlocked && paddr == ADDR_CTRL)
    begin
      if (pwdata[RUN_LSB +: 4] == RUN_STOP_CODE)
        run_d = RUN_STOPPED;
      else
        run_d = RUN_ACTIVE;
    end
  end

  // Configuration registers.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      debug_run_enable_q <= DEBUG_RUN_ENABLE_RST;
      div_q   <= DIV_RST;
      src_q   <= SRC_RST;
      key_q   <= KEY_RST;
      run_q   <= RUN_STOPPED;
    end
    else if (clkEn)
    begin
      debug_run_enable_q <= debug_run_enable_d;
      div_q   <= div_d;
      src_q   <= src_d;
      key_q   <= key_d;
      run_q   <= run_d;
    end
  end

  // Prescaler; a restart also clears it so the period is whole.
  // The compare is >= so a smaller new divider cannot cause a long lap.
  always_comb
  begin
    preCnt_d = preCnt_q;
    tick     = 1'b0;
    if (restartHit)
      preCnt_d = 16'h0000;
    else if (advance)
    begin
      if (preCnt_q >= term)
      begin
        preCnt_d = 16'h0000;
        tick     = 1'b1;
      end
      else
        preCnt_d = 16'(preCnt_q + 1'b1);
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      preCnt_q <= 16'h0000;
    else if (clkEn)
      preCnt_q <= preCnt_d;
  end

  // Counter hookup.
  assign cntBus.tick  = tick;
  assign cntBus.clear = restartHit;
  assign cntBus.run   = running;

  wdtrt_counter u_counter (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .clkEn   (clkEn),
    .cntBus  (cntBus)
  );

  // Bus answer and reset request next values.
  always_comb
  begin
    pready_d  = psel & penable & ~pready_q;
    pslverr_d = psel & penable & ~pready_q & ~addrHit;
    prdata_d  = prdata_q;
    rstReq_d  = cntBus.overflow;
    if (rdStart)
    begin
      prdata_d = 32'h0000_0000;
      if (paddr == ADDR_CLKSEL)
      begin
        prdata_d[DEBUG_RUN_ENABLE_BIT]     = debug_run_enable_q;
        prdata_d[DIV_LSB +: 2]  = div_q;
        prdata_d[SRC_LSB +: 2]  = src_q;
      end
      else if (paddr == ADDR_CTRL)
        prdata_d[RUN_LSB +: 4] = running ? RUN_ACT_READ : RUN_STOP_CODE;
      else if (paddr == ADDR_KEY)
        prdata_d[15:0] = key_q;
    end
  end

  // Bus and reset outputs come straight from these flops.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      rstReq_q  <= 1'b0;
    end
    else if (clkEn)
    begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
      rstReq_q  <= rstReq_d;
    end
  end

  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign systemResetReq = rstReq_q;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  a_restart_clears: assert property (
    clkEn && restartHit |=> cntBus.count == 10'h000 && preCnt_q == 16'h0000)
    else $error("Restart did not clear the count.");

  a_overflow_reset: assert property (
    clkEn && running && tick && !restartHit && cntBus.count == CNT_MAX
    |=> systemResetReq && cntBus.count == 10'h000)
    else $error("Overflow did not raise the reset request.");

  a_reset_one_pulse: assert property (
    clkEn && systemResetReq |=> !systemResetReq)
    else $error("Reset request lasted more than one cycle.");

  a_stop_holds: assert property (
    clkEn && !running && !restartHit |=> $stable(cntBus.count))
    else $error("Stopped watchdog changed its count.");

  a_debug_freeze: assert property (
    clkEn && debugMode && !debug_run_enable_q && !restartHit
    |=> $stable(cntBus.count) && $stable(preCnt_q))
    else $error("Count moved while gated in debug.");

  a_locked_ignore: assert property (
    clkEn && wrXfer && !unlocked && paddr != ADDR_KEY
    |=> $stable({debug_run_enable_q, div_q, src_q, run_q}))
    else $error("Locked write changed a protected field.");

  a_src_legal: assert property (
    SRC_AVAIL[src_q])
    else $error("Unimplemented source is selected.");

  a_run_readback: assert property (
    clkEn && rdStart && paddr == ADDR_CTRL
    |=> prdata[4:0] == ($past(running) ? 5'h00 : 5'h0a) && pready)
    else $error("Control read returned a wrong run field.");

  a_divide_term: assert property (
    clkEn && advance && !restartHit && preCnt_q >= term
    |=> preCnt_q == 16'h0000)
    else $error("Prescaler did not wrap at its terminal count.");

  // An unlocked clock register write shows in the cycle after pready is seen.
  a_clksel_write: assert property (
    clkEn && wrXfer && unlocked && paddr == ADDR_CLKSEL
    |=> debug_run_enable_q == $past(pwdata[DEBUG_RUN_ENABLE_BIT]) && div_q == $past(pwdata[DIV_LSB +: 2]))
    else $error("Clock register write did not land.");

  // The key must stay writable while locked, or software could never unlock.
  a_key_write: assert property (
    clkEn && wrXfer && paddr == ADDR_KEY |=> key_q == $past(pwdata[15:0]))
    else $error("Protection key write did not land.");

  // Any run code other than the stop code starts the watchdog.
  a_run_start: assert property (
    clkEn && wrXfer && unlocked && paddr == ADDR_CTRL
    |=> running == ($past(pwdata[RUN_LSB +: 4]) != RUN_STOP_CODE))
    else $error("Run field write gave the wrong run state.");

endmodule
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import wdtrt_pkg::*;

  logic        sys_clk   = 1'b0;
  logic        rstn      = 1'b0;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [11:0] paddr     = 12'h000;
  logic [31:0] pwdata    = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        extClkIn  = 1'b0;
  logic        debugMode = 1'b0;
  logic        clkEn     = 1'b1;
  logic        systemResetReq;
  logic [31:0] seed      = 32'hf823f5e5;
  logic [31:0] mClk      = 32'h0;
  logic [15:0] mKey      = 16'h0;
  logic        mRun      = 1'b0;
  int          mCnt      = 0;
  int          pend      = 0;
  int          n_errors  = 0;
  int          n_tests   = 0;
  int          cyc       = 0;

  // The three slow sources stay quiet; the fast external input drives every count.
  wdtrt_top DUT (
    .sys_clk        (sys_clk),
    .rstn           (rstn),
    .clkEn          (clkEn),
    .psel           (psel),
    .penable        (penable),
    .pwrite         (pwrite),
    .paddr          (paddr),
    .pwdata         (pwdata),
    .prdata         (prdata),
    .pready         (pready),
    .pslverr        (pslverr),
    .internalOsc    (1'b0),
    .lowSpeedXtal   (1'b0),
    .highSpeedOsc   (1'b0),
    .extClkIn       (extClkIn),
    .debugMode      (debugMode),
    .systemResetReq (systemResetReq)
  );

  // Free-running 50 MHz system clock.
  always #10 sys_clk = ~sys_clk;

  task automatic end_sim();
    $display("errors %0d, comparisons %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // The run needs about 76000 cycles, so a hang is cut off well past that.
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      n_errors++;
      end_sim();
    end
  end

  // Each reset pulse must match one overflow predicted by the model.
  always @(posedge sys_clk)
  begin
    if (systemResetReq === 1'b1)
    begin
      chk("reset pulse due", 32'h1, 32'(pend > 0));
      if (pend > 0)
        pend--;
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic bad(input logic [11:0] a);
    return !(a == ADDR_CLKSEL || a == ADDR_CTRL || a == ADDR_KEY);
  endfunction

  // One APB transfer; the request is held until pready is seen high, or for at most 50 cycles.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    k = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk("pready", 32'h1, {31'h0, pready});
  endtask

  // Key writes always update the model; clock and control writes only while the protection key is open.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    logic        ok;
    ok = (mKey == UNLOCK_KEY);
    apb(1'b1, a, d, r, e);
    if (a == ADDR_KEY)
      mKey = d[15:0];
    else if (a == ADDR_CLKSEL && ok)
      mClk = d & 32'h133;
    else if (a == ADDR_CTRL && ok)
    begin
      mRun = (d[3:0] != RUN_STOP_CODE);
      if (d[RESTART_BIT])
        mCnt = 0;
    end
    chk("write pslverr", 32'(bad(a)), {31'h0, e});
  endtask

  task automatic rd(input logic [11:0] a);
    logic [31:0] r;
    logic        e;
    logic [31:0] x;
    apb(1'b0, a, 32'h0, r, e);
    x = 32'h0;
    if (a == ADDR_CLKSEL)
      x = mClk;
    else if (a == ADDR_CTRL)
      x = {28'h0, mRun ? RUN_ACT_READ : RUN_STOP_CODE};
    else if (a == ADDR_KEY)
      x = {16'h0, mKey};
    chk("read data", x, r);
    chk("read pslverr", 32'(bad(a)), {31'h0, e});
  endtask

  // Rising edges eight cycles apart, slow enough for the source synchroniser.
  task automatic edges(input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      extClkIn <= 1'b1;
      if (clkEn && mRun && mClk[1:0] == SRC_EXTERNAL && !(debugMode && !mClk[DEBUG_RUN_ENABLE_BIT]))
        mCnt++;
      if (mCnt == 1024)
      begin
        mCnt = 0;
        pend++;
      end
      repeat (4) @(posedge sys_clk);
      extClkIn <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
    repeat (12) @(posedge sys_clk);
    chk("missing pulses", 32'h0, 32'(pend));
  endtask

  // Main sequence: registers first, then timing of the counter.
  initial
  begin
    logic [31:0] v;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(ADDR_CLKSEL);
    rd(ADDR_CTRL);
    rd(ADDR_KEY);
    rd(12'h00c);
    wr(12'h010, rnd());
    wr(ADDR_CLKSEL, rnd());
    wr(ADDR_CTRL, 32'h00000015);
    rd(ADDR_CLKSEL);
    rd(ADDR_CTRL);
    wr(ADDR_KEY, {16'h0, UNLOCK_KEY});
    for (int s = 0; s < NUM_SRC; s++)
    begin
      v = rnd();
      wr(ADDR_CLKSEL, {v[31:2], 2'(s)});
      rd(ADDR_CLKSEL);
    end
    for (int r = 0; r < 16; r++)
    begin
      wr(ADDR_CTRL, {27'h0, 1'b1, 4'(r)});
      rd(ADDR_CTRL);
    end
    wr(ADDR_CTRL, 32'h0000000a);
    v = rnd();
    wr(ADDR_CLKSEL, {v[31:9], 1'b0, v[7:2], SRC_EXTERNAL});
    wr(ADDR_CTRL, 32'h00000015);
    v = rnd();
    wr(ADDR_KEY, {v[31:8], 8'h00});
    wr(ADDR_CTRL, 32'h0000000a);
    edges(1024);
    edges(1000);
    wr(ADDR_KEY, {16'h0, UNLOCK_KEY});
    wr(ADDR_CTRL, 32'h00000015);
    edges(1000);
    edges(24);
    edges(400);
    debugMode <= 1'b1;
    edges(300);
    debugMode <= 1'b0;
    repeat (2000) @(posedge sys_clk);
    edges(624);
    wr(ADDR_CLKSEL, 32'h00000103);
    debugMode <= 1'b1;
    edges(1024);
    debugMode <= 1'b0;
    edges(300);
    wr(ADDR_CLKSEL, 32'h00000100);
    edges(200);
    wr(ADDR_CLKSEL, 32'h00000103);
    // A low clock enable parks every flop, so these edges must be lost.
    clkEn <= 1'b0;
    edges(100);
    clkEn <= 1'b1;
    edges(200);
    wr(ADDR_CTRL, 32'h0000000a);
    edges(1100);
    wr(ADDR_CTRL, 32'h00000005);
    edges(524);
    edges(300);
    wr(ADDR_CTRL, 32'h0000001a);
    edges(50);
    wr(ADDR_CTRL, 32'h00000015);
    edges(1024);
    end_sim();
  end

endmodule
`default_nettype wire
